// ===== vmll_limiter.v
// vmll_limiter.v: per-port, per-VLAN limiter on dynamic address learning
// assumes: AXI4-Lite master on aclk; ingress pipeline on aclk gives one
// request at a time and holds it until req_ready is high at a clock edge
`timescale 1ns/1ns
`default_nettype none
`include "vmll_consts.vh"
module vmll_limiter #(
	parameter RULES = `VMLL_RULES
) (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address and data
	input  wire        s_awvalid,
	output reg         s_awready,
	input  wire [7:0]  s_awaddr,
	input  wire [2:0]  s_awprot,
	input  wire        s_wvalid,
	output reg         s_wready,
	input  wire [31:0] s_wdata,
	input  wire [3:0]  s_wstrb,
	// axi4-lite write response
	output reg         s_bvalid,
	input  wire        s_bready,
	output reg  [1:0]  s_bresp,
	// axi4-lite read
	input  wire        s_arvalid,
	output reg         s_arready,
	input  wire [7:0]  s_araddr,
	input  wire [2:0]  s_arprot,
	output reg         s_rvalid,
	input  wire        s_rready,
	output reg  [31:0] s_rdata,
	output reg  [1:0]  s_rresp,
	// learning request from ingress pipeline
	input  wire        req_valid,
	output reg         req_ready,
	input  wire        req_age,
	input  wire [5:0]  req_port,
	input  wire [11:0] req_vid,
	input  wire        req_known,
	input  wire [14:0] req_psec_limit,
	// verdict for a frame lookup
	output reg         res_valid,
	output reg         res_fwd,
	output reg         res_learn
);
	localparam S_INIT  = 2'h0;
	localparam S_IDLE  = 2'h1;
	localparam S_MATCH = 2'h2;
	localparam S_DEC   = 2'h3;

	reg  [1:0]  ctrl;
	reg  [4:0]  sel;
	reg  [31:0] t_used;
	reg  [31:0] t_act;
	reg  [31:0] t_len;
	reg  [31:0] t_any;
	reg  [5:0]  t_port [0:RULES-1];
	reg  [11:0] t_vid  [0:RULES-1];
	reg  [14:0] t_lim  [0:RULES-1];
	reg  [5:0]  usage;
	reg  [1:0]  state;
	reg  [4:0]  init_idx;
	reg         clr_pend;
	reg  [4:0]  clr_idx;
	reg         k_age;
	reg  [5:0]  k_port;
	reg  [11:0] k_vid;
	reg         k_known;
	reg  [14:0] k_psec;
	reg         k_hit;
	reg  [4:0]  k_idx;
	reg  [7:0]  aw_a;
	reg  [31:0] w_d;
	reg  [3:0]  w_s;
	wire [31:0] hit_vec;
	wire [14:0] cnt;
	reg         m_hit;
	reg  [4:0]  m_idx;
	reg  [5:0]  next_usage;
	reg         mem_we;
	reg  [4:0]  mem_wa;
	reg  [14:0] mem_wd;
	integer     i;
	integer     ui;
	integer     mi;

	// address decode, shared by the read path and the write response
	function addr_ok;
		input [7:0] a;
		begin
			addr_ok = (a == `VMLL_A_CTRL) || (a == `VMLL_A_USAGE) ||
				(a == `VMLL_A_SEL) || (a == `VMLL_A_CFG) ||
				(a == `VMLL_A_LIMIT);
		end
	endfunction

	function [31:0] reg_val;
		input [7:0] a;
		begin
			case (a)
			`VMLL_A_CTRL:  reg_val = {30'h0, ctrl};
			`VMLL_A_USAGE: reg_val = {26'h0, usage};
			`VMLL_A_SEL:   reg_val = {27'h0, sel};
			`VMLL_A_CFG:   reg_val = {4'h0, t_vid[sel], 6'h0, t_port[sel],
				t_any[sel], t_len[sel], t_act[sel], t_used[sel]};
			`VMLL_A_LIMIT: reg_val = {17'h0, t_lim[sel]};
			default:       reg_val = 32'h0;
			endcase
		end
	endfunction

	// byte lanes not strobed keep their old contents
	wire [31:0] w_mask = {{8{w_s[3]}}, {8{w_s[2]}}, {8{w_s[1]}}, {8{w_s[0]}}};
	wire [31:0] w_new  = (reg_val(aw_a) & ~w_mask) | (w_d & w_mask);
	// a write waits while a counter clear is still owed
	wire        wr_fire = !s_awready && !s_wready && !s_bvalid && !clr_pend;
	wire        wr_rule = wr_fire &&
		((aw_a == `VMLL_A_CFG) || (aw_a == `VMLL_A_LIMIT));

	// write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			s_bvalid  <= 1'b0;
			s_bresp   <= `VMLL_RESP_OK;
			aw_a      <= 8'h00;
			w_d       <= 32'h0;
			w_s       <= 4'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_a      <= s_awaddr;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_d      <= s_wdata;
				w_s      <= s_wstrb;
				s_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_bvalid <= 1'b1;
				s_bresp  <= addr_ok(aw_a) ? `VMLL_RESP_OK : `VMLL_RESP_ERR;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid  <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	// registers and rule table
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl   <= 2'h0;
			sel    <= 5'h00;
			t_used <= 32'h0;
			t_act  <= 32'h0;
			t_len  <= 32'h0;
			t_any  <= 32'h0;
			for (i = 0; i < RULES; i = i + 1) begin
				t_port[i] <= 6'h00;
				t_vid[i]  <= 12'h000;
				t_lim[i]  <= 15'h0000;
			end
		end else if (wr_fire) begin
			case (aw_a)
			`VMLL_A_CTRL: ctrl <= w_new[1:0];
			`VMLL_A_SEL:  sel  <= w_new[4:0];
			`VMLL_A_CFG: begin
				t_used[sel] <= w_new[`VMLL_CFG_USED];
				t_act[sel]  <= w_new[`VMLL_CFG_ACT];
				t_len[sel]  <= w_new[`VMLL_CFG_LEN];
				t_any[sel]  <= w_new[`VMLL_CFG_ANY];
				t_port[sel] <= w_new[`VMLL_CFG_PORT +: `VMLL_PORT_W];
				t_vid[sel]  <= w_new[`VMLL_CFG_VID +: `VMLL_VID_W];
			end
			`VMLL_A_LIMIT: t_lim[sel] <= w_new[14:0];
			default: ;
			endcase
		end
	end

	// read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0;
			s_rresp   <= `VMLL_RESP_OK;
		end else begin
			if (s_arvalid && s_arready) begin
				s_arready <= 1'b0;
				s_rvalid  <= 1'b1;
				s_rdata   <= reg_val(s_araddr);
				s_rresp   <= addr_ok(s_araddr) ? `VMLL_RESP_OK : `VMLL_RESP_ERR;
			end
			if (s_rvalid && s_rready) begin
				s_rvalid  <= 1'b0;
				s_arready <= 1'b1;
			end
		end
	end

	// entries in use
	always @* begin
		next_usage = 6'h00;
		for (ui = 0; ui < RULES; ui = ui + 1) begin
			next_usage = next_usage + {5'h00, t_used[ui]};
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			usage <= 6'h00;
		end else begin
			usage <= next_usage;
		end
	end

	// rule match against the held key, one comparator per entry
	genvar g;
	generate
		for (g = 0; g < RULES; g = g + 1) begin : g_match
			assign hit_vec[g] = t_used[g] && t_act[g] &&
				(t_vid[g] == k_vid) && (t_any[g] || t_port[g] == k_port);
		end
	endgenerate

	// lowest-numbered matching rule wins
	always @* begin
		m_hit = 1'b0;
		m_idx = 5'h00;
		for (mi = RULES - 1; mi >= 0; mi = mi - 1) begin
			if (hit_vec[mi]) begin
				m_hit = 1'b1;
				m_idx = mi[4:0];
			end
		end
	end

	// verdict terms, valid in S_DEC while the counter word is on cnt
	wire [14:0] lim_r  = (t_lim[k_idx] == 15'h0000) ?
		`VMLL_LIMIT_MAX : t_lim[k_idx];
	wire        psec_s = (k_psec != 15'h0000) && (k_psec < lim_r);
	wire [14:0] eff    = psec_s ? k_psec : lim_r;
	wire        full   = cnt >= eff;
	wire        enf    = k_hit && ctrl[`VMLL_CTRL_EN] && t_len[k_idx];
	wire        learn  = !k_known && !(enf && full);
	wire        fwd    = !(!k_known && enf && full && ctrl[`VMLL_CTRL_DROP]);
	wire        inc    = k_hit && learn && (cnt != `VMLL_LIMIT_MAX);
	wire        dec    = k_hit && (cnt != 15'h0000);

	// counter write port: init sweep, rule clear, or verdict update
	always @* begin
		mem_we = 1'b0;
		mem_wa = k_idx;
		mem_wd = 15'h0000;
		case (state)
		S_INIT: begin
			mem_we = 1'b1;
			mem_wa = init_idx;
		end
		S_IDLE: begin
			mem_we = clr_pend;
			mem_wa = clr_idx;
		end
		S_DEC: begin
			mem_we = k_age ? dec : inc;
			mem_wd = k_age ? cnt - 15'h0001 : cnt + 15'h0001;
		end
		default: ;
		endcase
	end

	vmll_mem #(
		.W  (`VMLL_CNT_W),
		.D  (RULES),
		.AW (`VMLL_IDX_W)
	) u_cnt (
		.aclk    (aclk),
		.wr_en   (mem_we),
		.wr_addr (mem_wa),
		.wr_data (mem_wd),
		.rd_addr (m_idx),
		.rd_data (cnt)
	);

	// request sequencer
	always @(posedge aclk) begin
		if (!aresetn) begin
			state     <= S_INIT;
			init_idx  <= 5'h00;
			clr_pend  <= 1'b0;
			clr_idx   <= 5'h00;
			req_ready <= 1'b0;
			res_valid <= 1'b0;
			res_fwd   <= 1'b0;
			res_learn <= 1'b0;
			k_age     <= 1'b0;
			k_port    <= 6'h00;
			k_vid     <= 12'h000;
			k_known   <= 1'b0;
			k_psec    <= 15'h0000;
			k_hit     <= 1'b0;
			k_idx     <= 5'h00;
		end else begin
			res_valid <= 1'b0;
			// an edited rule restarts its count from zero
			if (wr_rule) begin
				clr_pend <= 1'b1;
				clr_idx  <= sel;
			end
			case (state)
			S_INIT: begin
				init_idx <= init_idx + 5'h01;
				if (init_idx == RULES - 1) begin
					state     <= S_IDLE;
					// a rule edited during the sweep owes its clear before any request
					req_ready <= !clr_pend && !wr_rule;
				end
			end
			S_IDLE: begin
				if (clr_pend) begin
					clr_pend  <= 1'b0;
					req_ready <= 1'b1;
				end else if (req_valid && req_ready) begin
					req_ready <= 1'b0;
					k_age     <= req_age;
					k_port    <= req_port;
					k_vid     <= req_vid;
					k_known   <= req_known;
					k_psec    <= req_psec_limit;
					state     <= S_MATCH;
				end else begin
					req_ready <= !wr_rule;
				end
			end
			S_MATCH: begin
				k_hit <= m_hit;
				k_idx <= m_idx;
				state <= S_DEC;
			end
			S_DEC: begin
				res_valid <= !k_age;
				res_fwd   <= fwd;
				res_learn <= learn;
				state     <= S_IDLE;
				req_ready <= !clr_pend && !wr_rule;
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // vmll_limiter
`default_nettype wire

// ===== vmll_consts.vh
// vmll_consts.vh: register map, field positions and sizes of the limiter
// assumes: included by bare name from the limiter design files
`ifndef VMLL_CONSTS_VH
`define VMLL_CONSTS_VH

// register byte addresses
`define VMLL_A_CTRL  8'h00
`define VMLL_A_USAGE 8'h04
`define VMLL_A_SEL   8'h08
`define VMLL_A_CFG   8'h0C
`define VMLL_A_LIMIT 8'h10

// control fields
`define VMLL_CTRL_EN   0
`define VMLL_CTRL_DROP 1

// rule configuration fields
`define VMLL_CFG_USED 0
`define VMLL_CFG_ACT  1
`define VMLL_CFG_LEN  2
`define VMLL_CFG_ANY  3
`define VMLL_CFG_PORT 4
`define VMLL_CFG_VID  16

// sizes
`define VMLL_RULES     32
`define VMLL_IDX_W     5
`define VMLL_PORT_W    6
`define VMLL_VID_W     12
`define VMLL_CNT_W     15
`define VMLL_LIMIT_MAX 15'h4000

// answer codes
`define VMLL_RESP_OK  2'h0
`define VMLL_RESP_ERR 2'h2

`endif

// ===== vmll_mem.v
// vmll_mem.v: learned-address counters, one word per rule
// assumes: one clock, write and registered read in the same cycle allowed
`timescale 1ns/1ns
`default_nettype none
module vmll_mem #(
	parameter W  = 15,
	parameter D  = 32,
	parameter AW = 5
) (
	// clock
	input  wire          aclk,
	// write port
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [W-1:0]  wr_data,
	// read port
	input  wire [AW-1:0] rd_addr,
	output reg  [W-1:0]  rd_data
);
	reg [W-1:0] mem [0:D-1];

	// no reset: the owner sweeps every word to zero after reset
	always @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // vmll_mem
`default_nettype wire

// ===== vmll_monitor.sv
// vmll_monitor.sv: verdict and handshake checks on the limiter ports
// assumes: bound onto vmll_limiter, single clock domain on aclk
`timescale 1ns/1ns
`default_nettype none
module vmll_monitor (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// read address and data
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic s_rvalid,
	// request and verdict
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_age,
	input wire logic req_known,
	input wire logic res_valid,
	input wire logic res_fwd,
	input wire logic res_learn
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire take = req_valid && req_ready;
	wire look = take && !req_age;
	chk_ans_lat: assert property (take && !req_age |-> ##3 res_valid)
		else $error("lookup verdict late");
	chk_age_quiet: assert property (take && req_age |-> ##3 !res_valid)
		else $error("age gave a verdict");
	chk_known_fwd: assert property (take && !req_age && req_known |-> ##3 res_fwd && !res_learn)
		else $error("known source not forwarded");
	chk_drop_nolearn: assert property (res_valid && !res_fwd |-> !res_learn)
		else $error("dropped frame learned");
	chk_learn_fwd: assert property (res_valid && res_learn |-> res_fwd)
		else $error("learned frame not forwarded");
	chk_ready_gap: assert property (take |=> !req_ready [*2])
		else $error("request taken too soon");
	chk_res_src: assert property (res_valid |-> $past(look, 3))
		else $error("verdict without lookup");
	chk_rd_lat: assert property (s_arvalid && s_arready |=> s_rvalid)
		else $error("read data late");
endmodule // vmll_monitor
bind vmll_limiter vmll_monitor i_mon (.*);
`default_nettype wire

// ===== vmll_ingress_model.sv
// vmll_ingress_model.sv: ingress pipeline side, one learning request at a time
// assumes: tb calls send right after a rising edge of aclk
`timescale 1ns/1ns
`default_nettype none
module vmll_ingress_model (
	// clock
	input  wire logic        aclk,
	// request
	output var  logic        req_valid,
	input  wire logic        req_ready,
	output var  logic        req_age,
	output var  logic [5:0]  req_port,
	output var  logic [11:0] req_vid,
	output var  logic        req_known,
	output var  logic [14:0] req_psec_limit,
	// verdict
	input  wire logic        res_valid,
	input  wire logic        res_fwd,
	input  wire logic        res_learn
);
	initial {req_valid, req_age, req_port, req_vid, req_known, req_psec_limit} = 36'h0;
	task send(input logic a, input logic [5:0] p, input logic [11:0] v, input logic k,
		input logic [14:0] s, output logic [1:0] r, output int n);
		@(posedge aclk);
		req_valid <= 1'b1;
		{req_age, req_port, req_vid, req_known, req_psec_limit} <= {a, p, v, k, s};
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (req_ready) break;
		end
		// released key shows its inverse, so a stale sample cannot pass
		req_valid <= 1'b0;
		{req_age, req_port, req_vid, req_known, req_psec_limit} <= ~{a, p, v, k, s};
		for (; n < 64 && !a; n++) begin
			@(posedge aclk);
			if (res_valid) break;
		end
		r = {res_fwd, res_learn};
	endtask
endmodule // vmll_ingress_model
`default_nettype wire

// ===== tb_top.sv
// tb_top.sv: register and lookup sequences for the learning limiter
// assumes: vmll_limiter with vmll_monitor bound, vmll_ingress_model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic        s_arvalid, s_arready, s_rvalid, s_rready, req_valid, req_ready, req_age;
	logic        req_known, res_valid, res_fwd, res_learn;
	logic [7:0]  s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata;
	logic [1:0]  s_bresp, s_rresp, r;
	logic [5:0]  req_port;
	logic [11:0] req_vid;
	logic [14:0] req_psec_limit;
	int          fail_count, checks_done, n, t;
	vmll_limiter i_dut (.*, .s_awprot(3'h0), .s_wstrb(4'hF), .s_arprot(3'h0));
	vmll_ingress_model i_ing (.*);
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// a used-up bound means the design never answered
	task bnd;
		if (n >= 64) begin
			fail_count++;
			close_out;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		{s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'h7};
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			if (s_bvalid) break;
		end
		s_bready <= 1'b0;
		bnd;
		chk(s_bresp, e);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		{s_araddr, s_arvalid, s_rready} <= {a, 2'h3};
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'b0;
			if (s_rvalid) break;
		end
		s_rready <= 1'b0;
		bnd;
		chk(s_rdata, d);
		chk(s_rresp, e);
	endtask
	task lk(input logic [5:0] p, input logic [11:0] v, input logic k, input logic [14:0] s,
		input logic [1:0] e);
		i_ing.send(1'b0, p, v, k, s, r, n);
		bnd;
		chk(r, e);
	endtask
	task ag(input logic [5:0] p);
		i_ing.send(1'b1, p, 12'h005, 1'b0, 15'h0000, r, n);
		bnd;
	endtask
	task tend;
		t++;
		$display("test %0d done", t);
	endtask
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, aresetn} = 6'h00;
		{s_awaddr, s_araddr, s_wdata} = 48'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (req_ready) break;
		end
		bnd;
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h14, 32'h0, 2'h2);
		wr(8'h14, 32'h1, 2'h2);
		wr(8'h04, 32'h5, 2'h0);
		rd(8'h04, 32'h0, 2'h0);
		wr(8'h10, 32'h2, 2'h0);
		wr(8'h0C, 32'h00050037, 2'h0);
		rd(8'h0C, 32'h00050037, 2'h0);
		rd(8'h04, 32'h1, 2'h0);
		tend;
		repeat (3) lk(6'h03, 12'h005, 1'b0, 15'h0, 2'h3);
		wr(8'h00, 32'h1, 2'h0);
		lk(6'h03, 12'h005, 1'b0, 15'h0, 2'h2);
		wr(8'h00, 32'h3, 2'h0);
		lk(6'h03, 12'h005, 1'b0, 15'h0, 2'h0);
		lk(6'h03, 12'h005, 1'b1, 15'h0, 2'h2);
		lk(6'h04, 12'h005, 1'b0, 15'h0, 2'h3);
		lk(6'h03, 12'h006, 1'b0, 15'h0, 2'h3);
		ag(6'h03);
		ag(6'h03);
		lk(6'h03, 12'h005, 1'b0, 15'h0, 2'h3);
		lk(6'h03, 12'h005, 1'b0, 15'h0, 2'h0);
		tend;
		wr(8'h10, 32'h0, 2'h0);
		lk(6'h03, 12'h005, 1'b0, 15'h0, 2'h3);
		lk(6'h03, 12'h005, 1'b0, 15'h1, 2'h0);
		ag(6'h03);
		lk(6'h03, 12'h005, 1'b0, 15'h1, 2'h3);
		tend;
		wr(8'h10, 32'h1, 2'h0);
		wr(8'h0C, 32'h0005000F, 2'h0);
		lk(6'h07, 12'h005, 1'b0, 15'h0, 2'h3);
		lk(6'h09, 12'h005, 1'b0, 15'h0, 2'h0);
		wr(8'h0C, 32'h0005000B, 2'h0);
		repeat (2) lk(6'h09, 12'h005, 1'b0, 15'h0, 2'h3);
		wr(8'h0C, 32'h0005000D, 2'h0);
		repeat (2) lk(6'h09, 12'h005, 1'b0, 15'h0, 2'h3);
		tend;
		wr(8'h0C, 32'h0, 2'h0);
		rd(8'h04, 32'h0, 2'h0);
		wr(8'h08, 32'h1F, 2'h0);
		wr(8'h0C, 32'h00050037, 2'h0);
		rd(8'h04, 32'h1, 2'h0);
		tend;
		close_out;
	end
endmodule // tb_top
`default_nettype wire
